/* File: hw/rtc_i2c_pkg.sv */
// Package for the RTC two-wire slave: bus address, timing counts, carriers.
// Assumes a 200 MHz core clock.
package rtc_i2c_pkg;
    localparam logic [6:0] RTC_DEV_ADDR = 7'h52;
    localparam int RTC_CLK_MHZ = 200;
    localparam int RTC_TIMEOUT_MS = 950;
    localparam int RTC_TIMEOUT_CYC = RTC_TIMEOUT_MS * 1000 * RTC_CLK_MHZ;
    localparam logic [7:0] RTC_PTR_RESET = 8'h00;
    localparam logic [7:0] RTC_IDLE_BYTE = 8'hff;

    typedef enum logic [2:0] {
        RTC_ST_IDLE,
        RTC_ST_ADDR,
        RTC_ST_ACK,
        RTC_ST_PTR,
        RTC_ST_WDATA,
        RTC_ST_RDATA,
        RTC_ST_MACK,
        RTC_ST_IGNORE
    } rtc_state_t;

    // Register access port toward the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtc_reg_req_t;

    // Conditions decoded from the bus lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } rtc_bus_ev_t;
endpackage

/* File: hw/rtc_i2c_sync.sv */
// Two-flop synchroniser and condition detector for the serial clock and data pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_sync (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output rtc_i2c_pkg::rtc_bus_ev_t ev
);
    import rtc_i2c_pkg::*;

    typedef struct packed {
        logic [1:0] scl_meta;
        logic [1:0] sda_meta;
        logic scl_q;
        logic sda_q;
    } rtc_sync_t;

    rtc_sync_t state;
    rtc_sync_t next_state;

    always_comb begin
        next_state = state;
        next_state.scl_meta = {state.scl_meta[0], scl_in};
        next_state.sda_meta = {state.sda_meta[0], sda_in};
        next_state.scl_q = state.scl_meta[1];
        next_state.sda_q = state.sda_meta[1];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_q: 1'b1, sda_q: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    // Only the second stage and later are read
    always_comb begin
        ev.sda = state.sda_meta[1];
        ev.scl_rise = state.scl_meta[1] && !state.scl_q;
        ev.scl_fall = !state.scl_meta[1] && state.scl_q;
        ev.start = state.scl_meta[1] && state.scl_q && state.sda_q && !state.sda_meta[1];
        ev.stop = state.scl_meta[1] && state.scl_q && !state.sda_q && state.sda_meta[1];
    end
endmodule
`default_nettype wire

/* File: hw/rtc_i2c_slave.sv */
// Two-wire slave protocol engine of the real-time clock: address match,
// pointer load, writes, random and current-address reads, timeout, backup hold.
// Assumes a register file that answers rd_data in the cycle after reg_req.rd.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave #(
    parameter int TIMEOUT_CYC = rtc_i2c_pkg::RTC_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic backup_supply_state,
    output rtc_i2c_pkg::rtc_reg_req_t reg_req,
    input wire logic [7:0] rd_data,
    output logic busy,
    output logic timed_out
);
    import rtc_i2c_pkg::*;

    typedef struct packed {
        rtc_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic drive_low;
        logic in_xfer;
        logic tmo;
        logic [31:0] tcnt;
        logic load_pend;
        logic [1:0] wsda_pend;
        // First read byte waits for its fetch before going out
        logic lead;
        // Backup flag comes from the power monitor, not this clock
        logic [1:0] bk_sync;
        rtc_reg_req_t req;
    } rtc_slv_t;

    rtc_i2c_pkg::rtc_bus_ev_t ev;
    rtc_slv_t state;
    rtc_slv_t next_state;

    rtc_i2c_sync u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    always_comb begin
        next_state = state;
        next_state.req.rd = 1'b0;
        next_state.req.wr = 1'b0;
        next_state.load_pend = state.req.rd;
        next_state.bk_sync = {state.bk_sync[0], backup_supply_state};
        // Read data arrives one cycle after the strobe
        if (state.load_pend) begin
            next_state.shift = state.tmo ? RTC_IDLE_BYTE : rd_data;
        end
        if (state.in_xfer && !state.tmo) begin
            if (state.tcnt >= 32'(TIMEOUT_CYC - 1)) begin
                next_state.tmo = 1'b1;
                next_state.st = RTC_ST_IGNORE;
                next_state.drive_low = 1'b0;
            end else begin
                next_state.tcnt = state.tcnt + 32'h1;
            end
        end
        if (ev.start) begin
            // Pointer deliberately untouched here
            next_state.st = RTC_ST_ADDR;
            next_state.bitcnt = 4'h0;
            next_state.drive_low = 1'b0;
            next_state.in_xfer = 1'b1;
            next_state.tmo = 1'b0;
            next_state.tcnt = 32'h0;
            next_state.lead = 1'b0;
            next_state.wsda_pend = 2'h0;
        end else if (ev.stop) begin
            next_state.st = RTC_ST_IDLE;
            next_state.drive_low = 1'b0;
            next_state.in_xfer = 1'b0;
            next_state.tmo = 1'b0;
            next_state.lead = 1'b0;
            next_state.wsda_pend = 2'h0;
        end else if (ev.scl_rise) begin
            case (state.st)
                RTC_ST_ADDR, RTC_ST_PTR, RTC_ST_WDATA: begin
                    next_state.shift = {state.shift[6:0], ev.sda};
                    next_state.bitcnt = state.bitcnt + 4'h1;
                end
                RTC_ST_MACK: begin
                    if (ev.sda) begin
                        next_state.st = RTC_ST_IGNORE;
                    end else begin
                        // Pointer already advanced when the byte was fetched
                        next_state.req.addr = state.ptr;
                        next_state.req.rd = 1'b1;
                        next_state.ptr = state.ptr + 8'h1;
                        next_state.st = RTC_ST_RDATA;
                        next_state.bitcnt = 4'h0;
                    end
                end
                default: begin
                end
            endcase
        end else if (ev.scl_fall) begin
            case (state.st)
                RTC_ST_ADDR: begin
                    if (state.bitcnt == 4'h8) begin
                        if (state.shift[7:1] == RTC_DEV_ADDR) begin
                            next_state.rw = state.shift[0];
                            next_state.drive_low = 1'b1;
                            next_state.st = RTC_ST_ACK;
                        end else begin
                            next_state.st = RTC_ST_IGNORE;
                        end
                    end
                end
                RTC_ST_PTR, RTC_ST_WDATA: begin
                    if (state.bitcnt == 4'h8) begin
                        next_state.drive_low = 1'b1;
                        if (state.st == RTC_ST_PTR) begin
                            next_state.ptr = state.shift;
                        end else begin
                            next_state.req.addr = state.ptr;
                            next_state.req.wdata = state.shift;
                            next_state.req.wr = 1'b1;
                            next_state.ptr = state.ptr + 8'h1;
                        end
                        next_state.wsda_pend = 2'h1;
                        next_state.st = RTC_ST_ACK;
                    end
                end
                RTC_ST_ACK: begin
                    next_state.drive_low = 1'b0;
                    next_state.bitcnt = 4'h0;
                    if (state.wsda_pend != 2'h0) begin
                        next_state.wsda_pend = 2'h0;
                        next_state.st = RTC_ST_WDATA;
                    end else if (!state.rw) begin
                        next_state.st = RTC_ST_PTR;
                    end else begin
                        // Random read: pointer as loaded; current read: next one
                        next_state.req.addr = state.ptr;
                        next_state.req.rd = 1'b1;
                        next_state.lead = 1'b1;
                        next_state.ptr = state.ptr + 8'h1;
                        next_state.st = RTC_ST_RDATA;
                    end
                end
                RTC_ST_RDATA: begin
                    if (state.bitcnt == 4'h0) begin
                        next_state.drive_low = !state.shift[7];
                    end else begin
                        next_state.shift = {state.shift[6:0], 1'b1};
                        next_state.drive_low = !state.shift[6];
                    end
                    if (state.bitcnt == 4'h8) begin
                        next_state.drive_low = 1'b0;
                        next_state.st = RTC_ST_MACK;
                    end
                    next_state.bitcnt = state.bitcnt + 4'h1;
                end
                default: begin
                end
            endcase
        end
        // First byte: bit 7 goes out once fetched, clock still low after the ack slot;
        // later bytes start on the ack-slot fall, never while the clock is high
        if (state.lead && next_state.st == RTC_ST_RDATA && !state.req.rd && !state.load_pend) begin
            next_state.drive_low = !state.shift[7];
            next_state.bitcnt = 4'h1;
            next_state.lead = 1'b0;
        end
        // Backup holds the protocol idle; pointer kept for later reads
        if (state.bk_sync[1]) begin
            next_state.st = RTC_ST_IDLE;
            next_state.drive_low = 1'b0;
            next_state.in_xfer = 1'b0;
            next_state.tmo = 1'b0;
            next_state.load_pend = 1'b0;
            next_state.lead = 1'b0;
            next_state.wsda_pend = 2'h0;
            next_state.req.rd = 1'b0;
            next_state.req.wr = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_n = !(state.drive_low && !state.bk_sync[1]);
    assign reg_req = state.req;
    assign busy = state.in_xfer;
    assign timed_out = state.tmo;
endmodule
`default_nettype wire

/* File: bench/rtc_i2c_slave_props.sv */
// Port checker for the two-wire slave.
// Assumes binding onto rtc_i2c_slave.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave_props #(
    parameter int TIMEOUT_CYC = 2000
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic backup_supply_state,
    input wire rtc_i2c_pkg::rtc_reg_req_t reg_req,
    input wire logic busy,
    input wire logic timed_out
);
    import rtc_i2c_pkg::*;
    int cnt;
    // Busy cycles since start; tolerance covers sync delay
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            cnt <= 0;
        else
            cnt <= busy ? cnt + 1 : 0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_bk; $rose(backup_supply_state) |-> ##[0:3] (sda_oe_n && !busy); endproperty
    a_bk: assert property (p_bk) else $error("backup release late");
    property p_bkh; backup_supply_state [*4] |-> sda_oe_n && !busy; endproperty
    a_bkh: assert property (p_bkh) else $error("active in backup");
    property p_wr; reg_req.wr |=> !reg_req.wr; endproperty
    a_wr: assert property (p_wr) else $error("write not a pulse");
    property p_rd; reg_req.rd |=> !reg_req.rd; endproperty
    a_rd: assert property (p_rd) else $error("read not a pulse");
    property p_od; !sda_oe_n |-> !sda_out && busy; endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    property p_edge; $changed(sda_oe_n) |-> !scl_in || backup_supply_state || timed_out; endproperty
    a_edge: assert property (p_edge) else $error("data changed with clock high");
    property p_toe; $rose(timed_out) |-> cnt >= TIMEOUT_CYC - 8; endproperty
    a_toe: assert property (p_toe) else $error("timeout early");
    property p_tol; busy && cnt == TIMEOUT_CYC + 8 |-> timed_out; endproperty
    a_tol: assert property (p_tol) else $error("timeout late");
    c_rd: cover property (reg_req.rd);
    c_wr: cover property (reg_req.wr);
    c_to: cover property ($rose(timed_out));
    c_bk: cover property ($rose(backup_supply_state));
endmodule
bind rtc_i2c_slave rtc_i2c_slave_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (.core_clk(core_clk),
    .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .backup_supply_state(backup_supply_state), .reg_req(reg_req), .busy(busy), .timed_out(timed_out));
`default_nettype wire

/* File: bench/rtc_i2c_master.sv */
// Bus master model driving the serial clock and data.
// Assumes a pull-up: released data reads high.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_master (
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    localparam time Q = 20ns;
    time gap = 0ns;
    // Clock stands high between frames
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    task automatic start();
        sda_rel = 1'h1;
        #Q scl = 1'h1;
        #Q sda_rel = 1'h0;
        #Q scl = 1'h0;
        #Q;
    endtask
    // Only called with the clock low
    task automatic stop();
        sda_rel = 1'h0;
        #Q scl = 1'h1;
        #Q sda_rel = 1'h1;
        #Q;
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_rel = b;
        #(Q + gap) scl = 1'h1;
        #Q r = sda;
        #Q scl = 1'h0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ar);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(a, ar);
    endtask
endmodule
`default_nettype wire

/* File: bench/rtc_i2c_slave_read_path_bench.sv */
// Bench: master model, register file model, scenarios.
// Assumes package and slave compile first.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave_read_path_bench;
    import rtc_i2c_pkg::*;
    localparam int TO = 2000;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    logic backup_supply_state = 1'h0;
    logic [7:0] rd_data = 8'h00;
    logic scl, m_rel, sda_out, sda_oe_n, busy, timed_out, a;
    logic [7:0] r;
    rtc_reg_req_t reg_req;
    rtc_reg_req_t last_wr = '0;
    int n_errors = 0;
    int tests_run = 0;
    wire logic sda_line;
    assign sda_line = m_rel & (sda_oe_n | sda_out);
    always #2.5 core_clk = ~core_clk;
    // Register file: contents are address xor 5a
    always @(negedge core_clk) begin
        if (reg_req.rd)
            rd_data <= reg_req.addr ^ 8'h5a;
        if (reg_req.wr)
            last_wr <= reg_req;
    end
    rtc_i2c_slave #(.TIMEOUT_CYC(TO)) dut (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .backup_supply_state(backup_supply_state), .reg_req(reg_req), .rd_data(rd_data),
        .busy(busy), .timed_out(timed_out));
    rtc_i2c_master m (.scl(scl), .sda_rel(m_rel), .sda(sda_line));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            n_errors++;
        end
    endtask
    task automatic snd(input logic [7:0] d, input logic ea);
        m.xfer(d, 1'h1, r, a);
        chk("ack", {7'h00, ea}, {7'h00, a});
    endtask
    task automatic rcv(input logic [7:0] e, input logic ma);
        m.xfer(8'hff, ma, r, a);
        chk("data", e, r);
    endtask
    task automatic t_random();
        m.start();
        snd(8'ha4, 1'h0);
        snd(8'h10, 1'h0);
        m.start();
        snd(8'ha5, 1'h0);
        rcv(8'h10 ^ 8'h5a, 1'h0);
        rcv(8'h11 ^ 8'h5a, 1'h0);
        rcv(8'h12 ^ 8'h5a, 1'h1);
        repeat (8) @(negedge core_clk);
        chk("release", 8'h01, {7'h00, sda_oe_n});
        m.stop();
    endtask
    // Slow master, pointer kept over stop
    task automatic t_stop_cur();
        m.gap = 100ns;
        m.start();
        snd(8'ha4, 1'h0);
        snd(8'h20, 1'h0);
        m.stop();
        m.start();
        snd(8'ha5, 1'h0);
        rcv(8'h20 ^ 8'h5a, 1'h1);
        m.stop();
        m.gap = 0ns;
        m.start();
        snd(8'ha5, 1'h0);
        rcv(8'h21 ^ 8'h5a, 1'h1);
        m.stop();
    endtask
    task automatic t_write();
        m.start();
        snd(8'ha4, 1'h0);
        snd(8'h30, 1'h0);
        snd(8'h77, 1'h0);
        chk("wr addr", 8'h30, last_wr.addr);
        chk("wr data", 8'h77, last_wr.wdata);
        m.start();
        snd(8'ha5, 1'h0);
        rcv(8'h31 ^ 8'h5a, 1'h1);
        m.stop();
    endtask
    task automatic t_other();
        m.start();
        snd(8'h90, 1'h1);
        m.start();
        m.bitx(1'h1, a);
        m.bitx(1'h0, a);
        m.start();
        snd(8'ha5, 1'h0);
        rcv(8'h32 ^ 8'h5a, 1'h1);
        m.stop();
    endtask
    // Backup hits just before the slave would drive a low bit
    task automatic t_backup();
        m.start();
        snd(8'ha4, 1'h0);
        snd(8'h40, 1'h0);
        m.start();
        snd(8'ha5, 1'h0);
        backup_supply_state = 1'h1;
        repeat (6) @(negedge core_clk);
        chk("backup oe", 8'h01, {7'h00, sda_oe_n});
        chk("backup busy", 8'h00, {7'h00, busy});
        backup_supply_state = 1'h0;
        repeat (6) @(negedge core_clk);
        m.stop();
        m.start();
        snd(8'ha4, 1'h0);
        m.stop();
    endtask
    task automatic t_timeout();
        m.start();
        snd(8'ha5, 1'h0);
        repeat (TO + 100) @(negedge core_clk);
        chk("timed out", 8'h01, {7'h00, timed_out});
        rcv(8'hff, 1'h1);
        m.stop();
        repeat (8) @(negedge core_clk);
        chk("timed out", 8'h00, {7'h00, timed_out});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Run takes about 35 us; hang margin is generous
    initial begin
        #200us;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge core_clk);
        resetn = 1'h1;
        repeat (5) @(negedge core_clk);
        t_random();
        t_stop_cur();
        t_write();
        t_other();
        t_backup();
        t_timeout();
        give_verdict();
    end
endmodule
`default_nettype wire
